// ==== sps_seq_top.sv ====
// Operation
// - five programs may run at once
// - at most 99 steps, numbered 1 to 99
// - programs see each other's ports and outputs
// - each step holds five fields
// - output pattern sets or clears 32 ports
// - input pattern checks 54 levels
// - first parameter holds skip or jump step
// - second parameter holds time, stitches or repeats
// - start at step 1, one step per 2 ms at most
// - outputs applied on step entry, before checks
// - hold the step until its condition holds
// - advance to next step or skip step
// - run until the completion command
// - terminals used raw, mapping ignored
// - virtual ports stay internal, no pins
// - virtual port direction set per bit
// - all program enables off after reset
// - mapping table holds function and active level
// - timed wait, then the next step
// - and/or branch, timeout jumps to skip step
// - repeat jumps back, zero loops forever
// - completion command stops its program
`timescale 1ns/1ps
module sps_seq_top
  import sps_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] in_term,
  input  wire logic [5:0]  op_sw,
  input  wire logic [15:0] vport_from_ctl,
  input  wire logic        stitch_pulse,
  output logic      [15:0] out_term,
  output logic      [15:0] vport_to_ctl
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0]    presc;
  logic             tick;
  logic [15:0]      in_s1;
  logic [15:0]      in_s2;
  logic [5:0]       sw_s1;
  logic [5:0]       sw_s2;
  logic [NPROG-1:0] prog_en;
  logic             srst;
  logic [2:0]       sel_prog;
  logic [6:0]       sel_step;
  logic [15:0]      vdir;
  logic [5:0]       map_sel;
  logic [8:0]       map_mem [0:MAP_N-1];
  logic [OW-1:0]    port_q;
  logic [OW-1:0]    next_port;
  logic [15:0]      vport_view;
  logic [IW-1:0]    in_vec;
  logic [NPROG-1:0] apply_v;
  logic [NPROG-1:0] run_v;
  logic [NPROG-1:0] fault_v;
  logic [OW-1:0]    hi_v   [NPROG];
  logic [OW-1:0]    lo_v   [NPROG];
  logic [6:0]       step_v [NPROG];
  logic [2:0]       cmd_v  [NPROG];
  logic             setup;
  logic             wr_acc;
  logic             fld_ok;
  logic [7:0]       fld_off;
  logic [31:0]      rdata_c;
  logic             hit_c;

  ////////////////////////////////////////////////////////////
  // 1 ms step tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
      tick  <= 1'b0;
    end else if (presc == TW'(TICK_CYCLES - 1)) begin
      presc <= '0;
      tick  <= 1'b1;
    end else begin
      presc <= presc + 1'b1;
      tick  <= 1'b0;
    end
  end

  // pins are asynchronous to pclk, two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      sw_s1 <= '0;
      sw_s2 <= '0;
    end else begin
      in_s1 <= in_term;
      in_s2 <= in_s1;
      sw_s1 <= op_sw;
      sw_s2 <= sw_s1;
    end
  end

  ////////////////////////////////////////////////////////////
  // condition vector seen by every program
  // controller-owned virtual bits come from the controller, the rest
  // are the level that the programs themselves last drove
  assign vport_view = (vport_from_ctl & ~vdir) | (port_q[OW-1:16] & vdir);
  // raw terminals, the function mapping plays no part here
  assign in_vec = {sw_s2, vport_view, in_s2, port_q[15:0]};

  ////////////////////////////////////////////////////////////
  // apb decode
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pready && pwrite;
  assign fld_off = paddr - A_FLD0;
  assign fld_ok  = (paddr >= A_FLD0) && (paddr <= A_FLDN) && (paddr[1:0] == 2'h0)
                && sps_step_ok(sel_step);

  ////////////////////////////////////////////////////////////
  // one engine per program, all running side by side
  genvar g;
  generate
    for (g = 0; g < NPROG; g++) begin : g_prog
      sps_prog_if pif ();
      assign pif.wr_en   = wr_acc && fld_ok && (sel_prog == 3'(g));
      assign pif.wr_fld  = fld_off[4:2];
      assign pif.wr_step = sel_step;
      assign pif.wr_data = pwdata;
      assign pif.enable  = prog_en[g];
      assign pif.srst    = srst;
      assign pif.tick    = tick;
      assign pif.stitch  = stitch_pulse;
      assign pif.in_vec  = in_vec;
      assign apply_v[g]  = pif.apply;
      assign run_v[g]    = pif.running;
      assign fault_v[g]  = pif.fault;
      assign hi_v[g]     = pif.drv_hi;
      assign lo_v[g]     = pif.drv_lo;
      assign step_v[g]   = pif.step;
      assign cmd_v[g]    = pif.cmd;
      sps_prog_eng u_eng (
        .pclk    (pclk),
        .presetn (presetn),
        .pi      (pif.eng)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////
  // control registers
  // srst is a one-cycle pulse; a write that also raises enables does
  // not start them, since the pulse and the edge land together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_en  <= '0;
      srst     <= 1'b0;
      sel_prog <= '0;
      sel_step <= STEP_FIRST;
      vdir     <= '0;
      map_sel  <= '0;
    end else begin
      srst <= 1'b0;
      if (wr_acc) begin
        case (paddr)
          A_CTRL: begin
            prog_en <= pwdata[NPROG-1:0];
            srst    <= pwdata[CTRL_SRST];
          end
          A_SEL: begin
            sel_prog <= pwdata[2:0];
            sel_step <= pwdata[SEL_STEP_LSB +: 7];
          end
          A_VDIR:  vdir    <= pwdata[15:0];
          A_MSEL:  map_sel <= pwdata[5:0];
          default: ;
        endcase
      end
    end
  end

  // port mapping table: function number plus active level
  // kept for the controller side only, programs never consult it
  always_ff @(posedge pclk) begin
    if (wr_acc && paddr == A_MDAT && map_sel <= MAP_LAST) begin
      map_mem[map_sel] <= pwdata[8:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // read mux; step fields are write-only and read as zero
  always_comb begin
    rdata_c = '0;
    hit_c   = 1'b1;
    case (paddr)
      A_CTRL: rdata_c[NPROG-1:0] = prog_en;
      A_STAT: begin
        rdata_c[NPROG-1:0]                = run_v;
        rdata_c[STAT_FLT_LSB +: NPROG]    = fault_v;
      end
      A_SEL: begin
        rdata_c[2:0]                 = sel_prog;
        rdata_c[SEL_STEP_LSB +: 7]   = sel_step;
      end
      A_VDIR: rdata_c[15:0] = vdir;
      A_CUR: begin
        for (int i = 0; i < NPROG; i++) begin
          if (sel_prog == 3'(i)) rdata_c[6:0] = step_v[i];
        end
      end
      A_MSEL: rdata_c[5:0] = map_sel;
      A_MDAT: begin
        if (map_sel <= MAP_LAST) rdata_c[8:0] = map_mem[map_sel];
      end
      A_PORT:  rdata_c = port_q;
      default: hit_c = (paddr >= A_FLD0) && (paddr <= A_FLDN);
    endcase
    if (paddr[1:0] != 2'h0) hit_c = 1'b0;
  end

  // answer is registered: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !hit_c;
      prdata  <= pwrite ? '0 : rdata_c;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // output pattern merge; the higher program wins a same-cycle clash
  always_comb begin
    next_port = port_q;
    for (int i = 0; i < NPROG; i++) begin
      if (apply_v[i]) next_port = (next_port | hi_v[i]) & ~lo_v[i];
    end
  end

  // virtual bits only leave toward the controller, never a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q       <= '0;
      vport_to_ctl <= '0;
    end else if (srst) begin
      port_q       <= '0;
      vport_to_ctl <= '0;
    end else begin
      port_q       <= next_port;
      vport_to_ctl <= next_port[OW-1:16] & vdir;
    end
  end

  assign out_term = port_q[15:0];

  ////////////////////////////////////////////////////////////
  // checks
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence

  chk_apb_answer: assert property (s_apb_setup |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

  chk_tick_period: assert property ($rose(tick) |-> $past(presc) == TW'(TICK_CYCLES - 1))
    else $error("step tick off its period");

  chk_enable_reset: assert property ($rose(presetn) |-> prog_en == '0 && port_q == '0)
    else $error("program enabled right after reset");

  chk_srst_idle: assert property (srst |=> run_v == '0 && port_q == '0)
    else $error("soft reset left a program or port active");

  chk_vport_dir: assert property ($stable(vdir) |-> (vport_to_ctl & ~vdir) == '0)
    else $error("virtual port driven against its direction");

  chk_map_write: assert property (wr_acc && paddr == A_MDAT && map_sel <= MAP_LAST
    |=> map_mem[$past(map_sel)] == $past(pwdata[8:0]))
    else $error("map entry not stored");

  for (g = 0; g < NPROG; g++) begin : g_chk
    sequence s_start;
      $rose(prog_en[g]) && !srst;
    endsequence
    sequence s_end_apply;
      apply_v[g] && cmd_v[g] == CMD_END;
    endsequence
    sequence s_lone_apply;
      apply_v[g] && $onehot(apply_v) && !srst;
    endsequence

    chk_start_step: assert property (s_start |=> run_v[g] && step_v[g] == STEP_FIRST)
      else $error("program did not start at the first step");

    chk_step_range: assert property (run_v[g] |-> sps_step_ok(step_v[g]))
      else $error("step number outside the valid range");

    chk_step_hold: assert property (run_v[g] && !tick |=> $stable(step_v[g]))
      else $error("step moved without a tick");

    chk_apply_tick: assert property (apply_v[g] |-> $past(tick))
      else $error("outputs applied off a tick");

    chk_end_stops: assert property (s_end_apply |-> !run_v[g])
      else $error("program kept running after completion");

    chk_out_follow: assert property (s_lone_apply
      |=> (port_q & $past(hi_v[g] & ~lo_v[g])) == $past(hi_v[g] & ~lo_v[g])
          && (port_q & $past(lo_v[g])) == '0)
      else $error("output pattern not applied");
  end
endmodule : sps_seq_top

// ==== sps_pkg.sv ====
package sps_pkg;
  localparam int NPROG    = 5;
  localparam int NSTEP    = 99;
  localparam int OW       = 32;
  localparam int IW       = 54;
  localparam int IN_SPLIT = 32;
  localparam int P2W      = 14;
  localparam int P2_LSB   = 16;
  localparam logic [6:0]     STEP_FIRST = 7'h01;
  localparam logic [6:0]     STEP_LAST  = 7'h63;
  localparam logic [6:0]     STEP_INC   = 7'h01;
  localparam logic [P2W-1:0] P2_ONE     = 14'h0001;
  // step time base
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SEL  = 8'h08;
  localparam logic [7:0] A_FLD0 = 8'h0C;
  localparam logic [7:0] A_FLDN = 8'h28;
  localparam logic [7:0] A_VDIR = 8'h2C;
  localparam logic [7:0] A_CUR  = 8'h30;
  localparam logic [7:0] A_MSEL = 8'h34;
  localparam logic [7:0] A_MDAT = 8'h38;
  localparam logic [7:0] A_PORT = 8'h3C;
  localparam int CTRL_SRST    = 8;
  localparam int SEL_STEP_LSB = 8;
  localparam int STAT_FLT_LSB = 8;
  localparam int MAP_N        = 54;
  localparam logic [5:0] MAP_LAST = 6'h35;
  typedef enum logic [2:0] {
    CMD_END = 3'h1, CMD_TIMED_WAIT = 3'h2, CMD_AND = 3'h3, CMD_OR = 3'h4,
    CMD_STITCH_ALL = 3'h5, CMD_STITCH_ANY = 3'h6, CMD_JUMP = 3'h7
  } sps_cmd_e;
  typedef enum logic [2:0] {
    F_CMD = 3'h0, F_OHI = 3'h1, F_OLO = 3'h2, F_IHA = 3'h3,
    F_IHB = 3'h4, F_ILA = 3'h5, F_ILB = 3'h6, F_PAR = 3'h7
  } sps_fld_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_ENTER = 2'h1, ST_WAIT = 2'h2
  } sps_state_e;
  function automatic logic sps_step_ok(input logic [6:0] s);
    return (s >= STEP_FIRST) && (s <= STEP_LAST);
  endfunction : sps_step_ok
endpackage : sps_pkg

// ==== sps_prog_if.sv ====
`timescale 1ns/1ps
interface sps_prog_if;
  import sps_pkg::*;
  logic           wr_en;
  logic [2:0]     wr_fld;
  logic [6:0]     wr_step;
  logic [31:0]    wr_data;
  logic           enable;
  logic           srst;
  logic           tick;
  logic           stitch;
  logic [IW-1:0]  in_vec;
  logic           apply;
  logic [OW-1:0]  drv_hi;
  logic [OW-1:0]  drv_lo;
  logic [2:0]     cmd;
  logic           running;
  logic           fault;
  logic [6:0]     step;
  modport eng (input wr_en, wr_fld, wr_step, wr_data, enable, srst, tick, stitch,
               in_vec, output apply, drv_hi, drv_lo, cmd, running, fault, step);
  modport ctl (output wr_en, wr_fld, wr_step, wr_data, enable, srst, tick, stitch,
               in_vec, input apply, drv_hi, drv_lo, cmd, running, fault, step);
endinterface : sps_prog_if

// ==== sps_prog_eng.sv ====
`timescale 1ns/1ps
module sps_prog_eng
  import sps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sps_prog_if.eng  pi
);
  logic [2:0]     cmd_m [1:NSTEP];
  logic [OW-1:0]  ohi_m [1:NSTEP];
  logic [OW-1:0]  olo_m [1:NSTEP];
  logic [IW-1:0]  ihi_m [1:NSTEP];
  logic [IW-1:0]  ilo_m [1:NSTEP];
  logic [6:0]     p1_m  [1:NSTEP];
  logic [P2W-1:0] p2_m  [1:NSTEP];
  sps_state_e     st;
  logic [6:0]     step;
  logic [6:0]     tgt;
  logic [P2W-1:0] cnt;
  logic [P2W-1:0] rep;
  logic [P2W-1:0] next_rep;
  logic           en_q;
  logic           go;
  logic           hit;
  logic           stitch_cmd;
  logic [2:0]     cmd;
  logic [P2W-1:0] p2;
  logic [IW-1:0]  ihi;
  logic [IW-1:0]  ilo;

  // step store, loaded from the bus one field at a time
  always_ff @(posedge pclk) begin
    if (pi.wr_en) begin
      case (pi.wr_fld)
        F_CMD:   cmd_m[pi.wr_step] <= pi.wr_data[2:0];
        F_OHI:   ohi_m[pi.wr_step] <= pi.wr_data;
        F_OLO:   olo_m[pi.wr_step] <= pi.wr_data;
        F_IHA:   ihi_m[pi.wr_step][IN_SPLIT-1:0] <= pi.wr_data;
        F_IHB:   ihi_m[pi.wr_step][IW-1:IN_SPLIT] <= pi.wr_data[IW-IN_SPLIT-1:0];
        F_ILA:   ilo_m[pi.wr_step][IN_SPLIT-1:0] <= pi.wr_data;
        F_ILB:   ilo_m[pi.wr_step][IW-1:IN_SPLIT] <= pi.wr_data[IW-IN_SPLIT-1:0];
        F_PAR: begin
          p1_m[pi.wr_step] <= pi.wr_data[6:0];
          p2_m[pi.wr_step] <= pi.wr_data[P2_LSB +: P2W];
        end
        default: ;
      endcase
    end
  end

  assign cmd        = cmd_m[step];
  assign p2         = p2_m[step];
  assign ihi        = ihi_m[step];
  assign ilo        = ilo_m[step];
  assign stitch_cmd = (cmd == CMD_STITCH_ALL) || (cmd == CMD_STITCH_ANY);
  // all-match for the and kinds, any-match for the or kinds
  assign hit = (cmd == CMD_AND || cmd == CMD_STITCH_ALL)
             ? (((pi.in_vec & ihi) == ihi) && ((~pi.in_vec & ilo) == ilo))
             : ((|(pi.in_vec & ihi)) || (|(~pi.in_vec & ilo)));
  assign pi.drv_hi  = ohi_m[step];
  assign pi.drv_lo  = olo_m[step];
  assign pi.cmd     = cmd;
  assign pi.step    = step;
  assign pi.running = (st != ST_IDLE);

  // decision taken on each tick while waiting
  always_comb begin
    go       = 1'b0;
    tgt      = step + STEP_INC;
    next_rep = rep;
    case (cmd)
      CMD_TIMED_WAIT: go = (cnt <= P2_ONE);
      CMD_AND, CMD_OR: begin
        if (hit) begin
          go = 1'b1;
        end else if (p2 != '0 && cnt <= P2_ONE) begin
          go  = 1'b1;
          tgt = p1_m[step];
        end
      end
      CMD_STITCH_ALL, CMD_STITCH_ANY: begin
        go = hit || (cnt == '0);
        if (hit) tgt = p1_m[step];
      end
      CMD_JUMP: begin
        go = 1'b1;
        if (p2 == '0) begin
          tgt = p1_m[step];
        end else if (rep == p2) begin
          next_rep = '0;
        end else begin
          next_rep = rep + P2_ONE;
          tgt      = p1_m[step];
        end
      end
      default: begin
        go  = 1'b1; // unknown code targets step 0 and faults
        tgt = '0;
      end
    endcase
  end

  // step sequencing, one decision per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= ST_IDLE;
      step     <= '0;
      cnt      <= '0;
      rep      <= '0;
      en_q     <= 1'b0;
      pi.apply <= 1'b0;
      pi.fault <= 1'b0;
    end else begin
      en_q     <= pi.enable;
      pi.apply <= 1'b0;
      if (pi.srst || !pi.enable) begin
        st <= ST_IDLE;
      end else begin
        case (st)
          ST_IDLE: if (!en_q) begin
            step     <= STEP_FIRST;
            rep      <= '0;
            pi.fault <= 1'b0;
            st       <= ST_ENTER;
          end
          ST_ENTER: if (pi.tick) begin
            pi.apply <= 1'b1;
            cnt      <= p2;
            st       <= (cmd == CMD_END) ? ST_IDLE : ST_WAIT;
          end
          ST_WAIT: begin
            if (stitch_cmd && pi.stitch && cnt != '0) cnt <= cnt - P2_ONE;
            if (pi.tick && go) begin
              rep <= next_rep;
              if (sps_step_ok(tgt)) begin
                step <= tgt;
                st   <= ST_ENTER;
              end else begin
                pi.fault <= 1'b1;
                st       <= ST_IDLE;
              end
            end else if (pi.tick && !stitch_cmd && cnt != '0) begin
              cnt <= cnt - P2_ONE;
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : sps_prog_eng

// ==== sps_mach_model.sv ====
`timescale 1ns/1ps
module sps_mach_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] in_req,
  input  wire logic [5:0]  sw_req,
  input  wire logic        stitch_req,
  input  wire logic [15:0] vport_to_ctl,
  output logic      [15:0] in_term,
  output logic      [5:0]  op_sw,
  output logic      [15:0] vport_from_ctl,
  output logic             stitch_pulse
);
  logic [1:0] gap;
  //////////////////////////////////////////////////////////////////////////////
  // terminals follow the wanted levels one edge late, like real wiring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_term        <= 16'h0000;
      op_sw          <= 6'h00;
      vport_from_ctl <= 16'h0000;
    end else begin
      in_term        <= in_req;
      op_sw          <= sw_req;
      vport_from_ctl <= ~vport_to_ctl ^ in_req; // busy pattern, never a stale copy
    end
  end
  // one-cycle stitch pulse every fourth cycle while sewing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap          <= 2'h0;
      stitch_pulse <= 1'b0;
    end else begin
      gap          <= gap + 2'h1;
      stitch_pulse <= stitch_req && (gap == 2'h3);
    end
  end
endmodule : sps_mach_model

// ==== sps_seq_top_bench.sv ====
`timescale 1ns/1ps
module sps_seq_top_bench;
  import sps_pkg::*;
  localparam int TK = 10;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r, exp_port = 32'h0, seed = 32'h65DB83CE;
  logic        pready, pslverr, err, stitch_pulse, prev, stitch_req = 1'b0;
  logic [15:0] in_term, vport_from_ctl, out_term, vport_to_ctl, in_req = 16'h0;
  logic [5:0]  op_sw, sw_req = 6'h0;
  int          n_fail = 0, checks = 0, cyc = 0, n, k;

  sps_seq_top #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .in_term, .op_sw, .vport_from_ctl,
    .stitch_pulse, .out_term, .vport_to_ctl);
  sps_mach_model u_mach (.pclk, .presetn, .in_req, .sw_req, .stitch_req, .vport_to_ctl,
    .in_term, .op_sw, .vport_from_ctl, .stitch_pulse);

  always #5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // reference model of the driven port word: set bits, then clear bits
  function automatic void mdl(input logic [31:0] hi, input logic [31:0] lo);
    exp_port = (exp_port | hi) & ~lo;
  endfunction : mdl

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // one transfer; request held until pready seen at an edge, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the hang guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic put_step(input logic [2:0] p, input logic [6:0] s, input logic [2:0] c,
                          input logic [31:0] ohi, input logic [31:0] olo,
                          input logic [31:0] ihl, input logic [31:0] ihh,
                          input logic [6:0] p1, input logic [13:0] p2);
    logic [31:0] f [8];
    f = '{{29'h0, c}, ohi, olo, ihl, ihh, 32'h0, 32'h0, {2'h0, p2, 9'h0, p1}};
    apb(1'b1, A_SEL, {17'h0, s, 5'h0, p});
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, A_FLD0 + 8'(4 * i), f[i]);
    end
  endtask : put_step

  // bounded wait for a terminal pattern; n counts the edges spent
  task automatic wait_out(input logic [15:0] v);
    n = 0;
    while (out_term !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_out

  task automatic cmp_port();
    chk("pins", {vport_to_ctl, out_term}, exp_port);
    apb(1'b0, A_PORT, 32'h0);
    chk("port_reg", rd, exp_port);
  endtask : cmp_port

  task automatic soft_rst();
    apb(1'b1, A_CTRL, 32'h100);
    // the clear pulse lands one edge after the write, so look one edge later
    @(posedge pclk);
    exp_port = 32'h0;
    chk("soft_reset", {vport_to_ctl, out_term}, 32'h0);
  endtask : soft_rst

  // hang guard: far above the roughly 1300 cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(1'b0, A_SEL, 32'h0);
    chk("step_sel", rd, 32'h100);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    cmp_port();
    apb(1'b1, A_VDIR, 32'hFFFF);
    // timed wait of three ticks, then completion
    put_step(0, 1, CMD_TIMED_WAIT, 32'h0001_0005, 0, 0, 0, 0, 3);
    put_step(0, 2, CMD_END, 0, 32'h1, 0, 0, 0, 0);
    apb(1'b1, A_CTRL, 32'h1);
    wait_out(16'h0005);
    mdl(32'h0001_0005, 0);
    chk("step1", {vport_to_ctl, out_term}, exp_port);
    wait_out(16'h0004);
    chk("wait_cycles", n, 4 * TK);
    mdl(0, 32'h1);
    cmp_port();
    repeat (3 * TK) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("stat", rd, 32'h0);
    // and/or branch on a terminal and a port driven by another program
    put_step(4, 1, CMD_END, 32'h0001_0000, 0, 0, 0, 0, 0);
    put_step(1, 2, CMD_END, 32'h8, 0, 0, 0, 0, 0);
    put_step(1, 3, CMD_END, 32'h10, 0, 0, 0, 0, 0);
    for (int j = 0; j < 4; j++) begin
      soft_rst();
      put_step(1, 1, j < 2 ? CMD_AND : CMD_OR, 0, 0, 32'h0001_0000, 32'h1, 3, 2);
      r = rnd();
      in_req <= {r[15:1], j[0]};
      apb(1'b1, A_CTRL, 32'h12);
      mdl(32'h0001_0000, 0);
      mdl(j == 0 ? 32'h10 : 32'h8, 0);
      wait_out(j == 0 ? 16'h0010 : 16'h0008);
      cmp_port();
    end
    // stitch branches: held without stitches and counted, or matched at once
    put_step(2, 2, CMD_END, 32'h20, 0, 0, 0, 0, 0);
    put_step(2, 3, CMD_END, 32'h40, 0, 0, 0, 0, 0);
    for (int j = 0; j < 2; j++) begin
      soft_rst();
      put_step(2, 1, j ? CMD_STITCH_ANY : CMD_STITCH_ALL, 0, 0, 0, 32'h0001_0000, 3, 3);
      r = rnd();
      sw_req <= {r[5:1], j[0]};
      apb(1'b1, A_CTRL, 32'h4);
      repeat (10 * TK) @(posedge pclk);
      mdl(j ? 32'h40 : 32'h0, 0);
      chk("held", {16'h0, out_term}, exp_port & 32'hFFFF);
      stitch_req <= 1'b1;
      wait_out(j ? 16'h0040 : 16'h0020);
      @(posedge pclk);
      stitch_req <= 1'b0;
      mdl(j ? 32'h0 : 32'h20, 0);
      cmp_port();
    end
    // repeat loop: two jumps back, so three pulses on terminal 8
    soft_rst();
    put_step(3, 1, CMD_TIMED_WAIT, 32'h100, 0, 0, 0, 0, 1);
    put_step(3, 2, CMD_TIMED_WAIT, 0, 32'h100, 0, 0, 0, 1);
    put_step(3, 3, CMD_JUMP, 0, 0, 0, 0, 1, 2);
    put_step(3, 4, CMD_END, 32'h200, 0, 0, 0, 0, 0);
    apb(1'b1, A_CTRL, 32'h8);
    k = 0;
    prev = 1'b0;
    n = 0;
    while (out_term[9] !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
      if (out_term[8] === 1'b1 && !prev) k++;
      prev = out_term[8];
    end
    chk("repeats", k, 3);
    mdl(32'h200, 0);
    cmp_port();
    // jump destination past the last step stops the program with a fault
    soft_rst();
    put_step(0, 1, CMD_JUMP, 0, 0, 0, 0, 7'h64, 0);
    apb(1'b1, A_CTRL, 32'h1);
    repeat (3 * TK) @(posedge pclk);
    apb(1'b0, A_STAT, 32'h0);
    chk("fault", rd, 32'h100);
    // mapping entry keeps function number and level
    r = rnd();
    apb(1'b1, A_MSEL, {26'h0, MAP_LAST});
    apb(1'b1, A_MDAT, {23'h0, r[8:0]});
    apb(1'b0, A_MDAT, 32'h0);
    chk("map_entry", rd, {23'h0, r[8:0]});
    tally_and_finish();
  end
endmodule : sps_seq_top_bench
